// ===== hw/nvm_regs_pkg.sv
// Package with register map, field layout and carrier types of the flash control registers
// Functional notes
// - Policy 0: sleep reduces, first access wakes
// - Policy 1: sleep reduces, sleep exit wakes
// - Policy 3 disables; 2 reserved
// - Manual bit 0: last buffer word starts programming
// - Manual bit 1 (reset): command-only programming
// - Read wait states 0..15, reset zero
// - Params top twelve bits: RWW page count
// - Page size code: 8 bytes shifted left
// - Params low sixteen bits: main page count
// - Enable-clear: write one clears enable
// - Enable-set: write one sets enable
// - Error flag sets on errors, W1C
// - Ready flag zero while busy, read-only
// - Status bit 8 shows security bit
// - Status bit 4: program/erase failure, W1C
// - Status bit 3: locked region program, W1C
// - Status bit 2: bad command or key, W1C
// - Status bit 1: buffer loaded, sticky
// - Status bit 0: power reduction state
package nvm_regs_pkg;
  // Byte offsets
  localparam logic [7:0] ctrl_off = 8'h04;
  localparam logic [7:0] params_off = 8'h08;
  localparam logic [7:0] ien_clr_off = 8'h0c;
  localparam logic [7:0] ien_set_off = 8'h10;
  localparam logic [7:0] flags_off = 8'h14;
  localparam logic [7:0] status_off = 8'h18;
  // Control field layout
  localparam int sleep_pol_lsb = 8;
  localparam int manual_write_pos = 7;
  localparam int wait_states_lsb = 1;
  localparam logic [31:0] ctrl_reset = 32'h0000_0080;
  // Sleep policy codes
  localparam logic [1:0] pol_wake_access = 2'h0;
  localparam logic [1:0] pol_wake_exit = 2'h1;
  localparam logic [1:0] pol_disabled = 2'h3;
  // Parameter field layout
  localparam int rww_lsb = 20;
  localparam int page_size_lsb = 16;
  // Flag and status bit positions
  localparam int ready_pos = 0;
  localparam int error_pos = 1;
  localparam int reduced_pos = 0;
  localparam int load_pos = 1;
  localparam int bad_cmd_pos = 2;
  localparam int lock_err_pos = 3;
  localparam int op_err_pos = 4;
  localparam int sec_pos = 8;
  // AXI responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Events from the flash engine side
  typedef struct packed {
    logic busy;
    logic op_fail;
    logic lock_viol;
    logic bad_cmd;
    logic buf_load;
    logic buf_last;
    logic page_write_cmd;
    logic buf_clear_cmd;
    logic reduce_set_cmd;
    logic reduce_clr_cmd;
    logic flash_access;
    logic sleep_enter;
    logic sleep_exit;
    logic security_active;
  } flash_evt_type;

  // Controls toward the flash engine
  typedef struct packed {
    logic auto_write_start;
    logic low_power;
    logic [3:0] read_wait_states;
  } flash_ctl_type;
endpackage

// ===== hw/nvm_power_ctl.sv
// Power reduction state tracker of the flash block
`timescale 1ns/1ps
`default_nettype none
module nvm_power_ctl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Policy and events
  input wire logic [1:0] policy,
  input wire logic set_cmd,
  input wire logic clr_cmd,
  input wire logic flash_access,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  // State
  output logic reduced
);
  logic reduced_r;
  logic reduced_nxt;
  wire auto_on = policy == nvm_regs_pkg::pol_wake_access || policy == nvm_regs_pkg::pol_wake_exit;
  // Entry wins over wake in the same cycle; sleep entry beats a stray access
  always_comb begin
    reduced_nxt = reduced_r;
    if (clr_cmd) reduced_nxt = 1'b0;
    if (flash_access) reduced_nxt = 1'b0;
    if (sleep_exit && policy == nvm_regs_pkg::pol_wake_exit) reduced_nxt = 1'b0;
    if (set_cmd) reduced_nxt = 1'b1;
    if (sleep_enter && auto_on) reduced_nxt = 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) reduced_r <= 1'b0;
    else reduced_r <= reduced_nxt;
  end
  assign reduced = reduced_r;
endmodule
`default_nettype wire

// ===== hw/nvm_ctrl_status_regs.sv
// Flash controller control, parameter, interrupt and status registers on AXI4-Lite
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module nvm_ctrl_status_regs #(
  parameter logic [11:0] rww_pages = 12'h000,
  parameter logic [2:0] page_size_code = 3'h0,
  parameter logic [15:0] main_pages = 16'h0000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash engine side
  input wire nvm_regs_pkg::flash_evt_type flash_evt,
  output nvm_regs_pkg::flash_ctl_type flash_ctl,
  // Interrupt request
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////////
  // Write channel capture
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  // Address and data are taken in either order, each held until the pair is done
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_r || aw_take;
  wire w_have = w_held_r || w_take;
  wire wr_fire = aw_have && w_have && !bvalid_r;
  wire [7:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_data_raw = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;

  // Byte lanes without strobe leave bits untouched, and write-one bits see zero
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction
  wire [31:0] wmask = lane_mask(wr_strb);
  wire [31:0] wr_data = wr_data_raw & wmask;

  // Offset check shared by reads and writes
  function automatic logic is_mapped(input logic [7:0] a);
    return a == nvm_regs_pkg::ctrl_off || a == nvm_regs_pkg::params_off ||
           a == nvm_regs_pkg::ien_clr_off || a == nvm_regs_pkg::ien_set_off ||
           a == nvm_regs_pkg::flags_off || a == nvm_regs_pkg::status_off;
  endfunction

  wire wr_ctrl = wr_fire && wr_addr == nvm_regs_pkg::ctrl_off;
  wire wr_ien_clr = wr_fire && wr_addr == nvm_regs_pkg::ien_clr_off;
  wire wr_ien_set = wr_fire && wr_addr == nvm_regs_pkg::ien_set_off;
  wire wr_flags = wr_fire && wr_addr == nvm_regs_pkg::flags_off;
  wire wr_status = wr_fire && wr_addr == nvm_regs_pkg::status_off;
  wire [1:0] wr_resp = is_mapped(wr_addr) ? nvm_regs_pkg::resp_okay : nvm_regs_pkg::resp_slverr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      aw_held_r <= aw_have && !wr_fire;
      w_held_r <= w_have && !wr_fire;
      if (aw_take) awaddr_r <= s_axi_awaddr;
      if (w_take) wdata_r <= s_axi_wdata;
      if (w_take) wstrb_r <= s_axi_wstrb;
    end
  end

  // Write response one cycle after the pair completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= nvm_regs_pkg::resp_okay;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_resp;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register
  logic [31:0] ctrl_r;
  localparam logic [31:0] ctrl_wmask = 32'h0000_039e;
  wire [31:0] ctrl_nxt = (ctrl_r & ~(wmask & ctrl_wmask)) | (wr_data & ctrl_wmask);
  always_ff @(posedge aclk) begin
    if (!aresetn) ctrl_r <= nvm_regs_pkg::ctrl_reset;
    else if (wr_ctrl) ctrl_r <= ctrl_nxt;
  end
  wire [1:0] sleep_power_policy = ctrl_r[nvm_regs_pkg::sleep_pol_lsb +: 2];
  wire manual_write_bit = ctrl_r[nvm_regs_pkg::manual_write_pos];
  wire [3:0] read_wait_states = ctrl_r[nvm_regs_pkg::wait_states_lsb +: 4];

  ////////////////////////////////////////////////////////////////////////////////
  // Power reduction tracking
  logic power_reduced_state;
  nvm_power_ctl u_power (
    .aclk(aclk),
    .aresetn(aresetn),
    .policy(sleep_power_policy),
    .set_cmd(flash_evt.reduce_set_cmd),
    .clr_cmd(flash_evt.reduce_clr_cmd),
    .flash_access(flash_evt.flash_access),
    .sleep_enter(flash_evt.sleep_enter),
    .sleep_exit(flash_evt.sleep_exit),
    .reduced(power_reduced_state)
  );

  // Controls to the engine; auto start only with the manual bit clear
  logic [3:0] wait_states_out_r;
  logic auto_start_r;
  logic low_power_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_states_out_r <= 4'h0;
      auto_start_r <= 1'b0;
      low_power_r <= 1'b0;
    end else begin
      wait_states_out_r <= read_wait_states;
      auto_start_r <= !manual_write_bit && flash_evt.buf_last;
      low_power_r <= power_reduced_state;
    end
  end
  // One driver for the whole control word, fields in struct order
  assign flash_ctl = {auto_start_r, low_power_r, wait_states_out_r};

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt enables, one shared pair behind the set and clear views
  logic [1:0] ien_r;
  wire [1:0] ien_nxt = (ien_r & ~(wr_ien_clr ? wr_data[1:0] : 2'h0)) | (wr_ien_set ? wr_data[1:0] : 2'h0);
  always_ff @(posedge aclk) begin
    if (!aresetn) ien_r <= 2'h0;
    else ien_r <= ien_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a new event wins over a write-one clear in the same cycle
  logic err_flag_r;
  logic op_err_r;
  logic lock_err_r;
  logic bad_cmd_r;
  logic load_r;
  wire any_err = flash_evt.op_fail || flash_evt.lock_viol || flash_evt.bad_cmd;
  wire clr_err = wr_flags && wr_data[nvm_regs_pkg::error_pos];
  wire clr_op = wr_status && wr_data[nvm_regs_pkg::op_err_pos];
  wire clr_lock = wr_status && wr_data[nvm_regs_pkg::lock_err_pos];
  wire clr_bad = wr_status && wr_data[nvm_regs_pkg::bad_cmd_pos];
  wire clr_load = (wr_status && wr_data[nvm_regs_pkg::load_pos]) ||
                  flash_evt.page_write_cmd || flash_evt.buf_clear_cmd || auto_start_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_flag_r <= 1'b0;
      op_err_r <= 1'b0;
      lock_err_r <= 1'b0;
      bad_cmd_r <= 1'b0;
      load_r <= 1'b0;
    end else begin
      err_flag_r <= any_err || (err_flag_r && !clr_err);
      op_err_r <= flash_evt.op_fail || (op_err_r && !clr_op);
      lock_err_r <= flash_evt.lock_viol || (lock_err_r && !clr_lock);
      bad_cmd_r <= flash_evt.bad_cmd || (bad_cmd_r && !clr_bad);
      load_r <= flash_evt.buf_load || (load_r && !clr_load);
    end
  end

  // Ready is live engine state, not stored
  wire ready_flag = !flash_evt.busy;
  wire [1:0] flags_now = {err_flag_r, ready_flag};

  // Interrupt level from enabled flags
  logic irq_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_r <= 1'b0;
    else irq_r <= |(flags_now & ien_r);
  end
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path
  wire [31:0] params_word = {rww_pages, 1'b0, page_size_code, main_pages};
  wire [31:0] status_word = {23'h0, flash_evt.security_active, 3'h0, op_err_r, lock_err_r, bad_cmd_r, load_r,
                             power_reduced_state};
  wire [31:0] ctrl_word = ctrl_r & ctrl_wmask;
  wire [31:0] ien_word = {30'h0, ien_r};
  wire [31:0] flags_word = {30'h0, flags_now};
  wire [31:0] rd_word =
    s_axi_araddr == nvm_regs_pkg::ctrl_off ? ctrl_word :
    s_axi_araddr == nvm_regs_pkg::params_off ? params_word :
    s_axi_araddr == nvm_regs_pkg::ien_clr_off ? ien_word :
    s_axi_araddr == nvm_regs_pkg::ien_set_off ? ien_word :
    s_axi_araddr == nvm_regs_pkg::flags_off ? flags_word :
    s_axi_araddr == nvm_regs_pkg::status_off ? status_word : 32'h0000_0000;

  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  assign s_axi_arready = !rvalid_r;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  // Read data registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= nvm_regs_pkg::resp_okay;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= is_mapped(s_axi_araddr) ? nvm_regs_pkg::resp_okay : nvm_regs_pkg::resp_slverr;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

// ===== testbench/nvm_regs_checker.sv
// Assertions on the ports of the flash register block
`timescale 1ns/1ps
`default_nettype none
module nvm_regs_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  // Flash side and interrupt
  input wire nvm_regs_pkg::flash_evt_type flash_evt,
  input wire nvm_regs_pkg::flash_ctl_type flash_ctl,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // Bus answers hold until taken
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while response pending");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  ////////////////////////////////////////////////////////////////
  // Flash side outputs only move for a cause
  chk_auto_cause: assert property (flash_ctl.auto_write_start |-> $past(flash_evt.buf_last))
    else $error("page write started without last buffer word");
  chk_wait_cause: assert property ($changed(flash_ctl.read_wait_states) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("wait states moved without a register write");
  chk_lp_enter: assert property ($rose(flash_ctl.low_power) |-> $past(flash_evt.reduce_set_cmd || flash_evt.sleep_enter, 2))
    else $error("low power entered without cause");
  chk_lp_leave: assert property ($fell(flash_ctl.low_power)
    |-> $past(flash_evt.reduce_clr_cmd || flash_evt.flash_access || flash_evt.sleep_exit, 2))
    else $error("low power left without cause");
  // Error pulse sets the flag at the next edge and the request one edge later
  chk_irq_raise: assert property ($rose(irq) |-> $past(s_axi_bvalid) || $past(flash_evt.busy, 2)
    || $past(flash_evt.op_fail || flash_evt.lock_viol || flash_evt.bad_cmd, 2))
    else $error("interrupt raised without cause");
  chk_irq_drop: assert property ($fell(irq) |-> $past(s_axi_bvalid) || $past(flash_evt.busy))
    else $error("interrupt dropped without cause");
  // Main scenarios reached
  cov_auto: cover property (flash_ctl.auto_write_start);
  cov_irq: cover property ($rose(irq));
  cov_lp: cover property ($rose(flash_ctl.low_power));
endmodule
bind nvm_ctrl_status_regs nvm_regs_checker chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bresp, .s_axi_rdata, .flash_evt, .flash_ctl, .irq);
`default_nettype wire

// ===== testbench/flash_engine_model.sv
// Behavioural flash engine: replays event pulses, goes busy after an automatic page write start
`timescale 1ns/1ps
`default_nettype none
module flash_engine_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench requests
  input wire logic [13:0] req,
  input wire logic slow,
  input wire logic secure,
  // Design side
  input wire nvm_regs_pkg::flash_ctl_type ctl,
  output nvm_regs_pkg::flash_evt_type evt
);
  logic [7:0] cnt_r;
  // Busy countdown, long or short so both answer speeds are seen
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_r <= 8'h00;
    else if (ctl.auto_write_start) cnt_r <= slow ? 8'h20 : 8'h02;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
  end
  // Pulses pass through; busy and security are levels
  always_comb begin
    evt = nvm_regs_pkg::flash_evt_type'(req);
    evt.busy = (cnt_r != 8'h00);
    evt.security_active = secure;
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench of the flash control and status registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [11:0] rww = 12'h0a5;
  localparam logic [2:0] page_code = 3'h7;
  localparam logic [15:0] mpg = 16'h1234;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [13:0] req = 14'h0000;
  logic slow = 1'b0;
  logic sec = 1'b0;
  logic [3:0] r, v;
  nvm_regs_pkg::flash_evt_type evt;
  nvm_regs_pkg::flash_ctl_type ctl;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_fail = 0;
  int check_count = 0;
  int n_auto = 0;
  always #5 aclk = ~aclk;
  nvm_ctrl_status_regs #(.rww_pages(rww), .page_size_code(page_code), .main_pages(mpg)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_evt(evt), .flash_ctl(ctl), .irq);
  flash_engine_model eng (.aclk, .aresetn, .req, .slow, .secure(sec), .ctl, .evt);
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input string w, input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Bus write; address and data each released on their own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bq.push_back(e);
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rq.push_back({e, d});
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // One-cycle event pulse, then let flags and outputs settle
  task automatic ev(input logic [13:0] m);
    @(posedge aclk);
    req <= m;
    @(posedge aclk);
    req <= 14'h0000;
    repeat (3) @(posedge aclk);
  endtask
  task automatic pw(input logic [31:0] c, input logic [13:0] m, input logic e);
    wr(nvm_regs_pkg::ctrl_off, c);
    ev(m);
    rd(nvm_regs_pkg::status_off, {31'h80, e});
    cmp("low_power", {33'h0, e}, {33'h0, ctl.low_power});
  endtask
  ////////////////////////////////////////////////////////////////
  // Result watcher: oldest note against each bus answer
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) cmp("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
  end
  always @(posedge aclk) if (ctl.auto_write_start) n_auto++;
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hd653c2a4));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, geometry, unmapped hole
    rd(nvm_regs_pkg::ctrl_off, 32'h80);
    rd(nvm_regs_pkg::params_off, {rww, 1'b0, page_code, mpg});
    wr(nvm_regs_pkg::params_off, 32'hffffffff);
    rd(nvm_regs_pkg::params_off, {rww, 1'b0, page_code, mpg});
    rd(nvm_regs_pkg::flags_off, 32'h1);
    rd(nvm_regs_pkg::status_off, 32'h0);
    rd(8'h1c, 32'h0, nvm_regs_pkg::resp_slverr);
    wr(8'h1c, 32'h1, nvm_regs_pkg::resp_slverr);
    sec <= 1'b1;
    rd(nvm_regs_pkg::status_off, 32'h100);
    // Shared enable state through both windows
    wr(nvm_regs_pkg::ien_set_off, 32'h3);
    rd(nvm_regs_pkg::ien_clr_off, 32'h3);
    cmp("irq", 34'h1, {33'h0, irq});
    wr(nvm_regs_pkg::ien_clr_off, 32'h1);
    rd(nvm_regs_pkg::ien_set_off, 32'h2);
    cmp("irq", 34'h0, {33'h0, irq});
    // Each error source: sticky bit, error flag, interrupt, write-one clear
    for (int i = 0; i < 3; i++) begin
      ev(14'h1000 >> i);
      rd(nvm_regs_pkg::status_off, 32'h100 | (32'h10 >> i));
      rd(nvm_regs_pkg::flags_off, 32'h3);
      cmp("irq", 34'h1, {33'h0, irq});
      wr(nvm_regs_pkg::flags_off, 32'h2);
      wr(nvm_regs_pkg::status_off, 32'h10 >> i);
      rd(nvm_regs_pkg::flags_off, 32'h1);
      rd(nvm_regs_pkg::status_off, 32'h100);
      cmp("irq", 34'h0, {33'h0, irq});
    end
    // Buffer load bit; manual mode must not start a page write
    ev(14'h0200);
    rd(nvm_regs_pkg::status_off, 32'h102);
    ev(14'h0040);
    rd(nvm_regs_pkg::status_off, 32'h100);
    ev(14'h0200);
    ev(14'h0100);
    rd(nvm_regs_pkg::status_off, 32'h102);
    cmp("auto", 34'h0, 34'(n_auto));
    // Every wait-state value in a random order
    r = 4'($urandom);
    for (int i = 0; i < 16; i++) begin
      v = 4'(i) ^ r;
      wr(nvm_regs_pkg::ctrl_off, {24'h0, 1'b1, 2'h0, v, 1'b0});
      @(posedge aclk);
      cmp("wait_states", 34'(v), 34'(ctl.read_wait_states));
      rd(nvm_regs_pkg::ctrl_off, {24'h0, 1'b1, 2'h0, v, 1'b0});
    end
    // Automatic page write, slow then prompt engine
    wr(nvm_regs_pkg::ctrl_off, 32'h0);
    slow <= 1'b1;
    ev(14'h0100);
    cmp("auto", 34'h1, 34'(n_auto));
    rd(nvm_regs_pkg::status_off, 32'h100);
    rd(nvm_regs_pkg::flags_off, 32'h0);
    repeat (40) @(posedge aclk);
    rd(nvm_regs_pkg::flags_off, 32'h1);
    slow <= 1'b0;
    ev(14'h0100);
    rd(nvm_regs_pkg::flags_off, 32'h1);
    cmp("auto", 34'h2, 34'(n_auto));
    // Sleep policies and command-driven power reduction
    pw(32'h000, 14'h0004, 1'b1);
    pw(32'h000, 14'h0002, 1'b1);
    pw(32'h000, 14'h0008, 1'b0);
    pw(32'h100, 14'h0004, 1'b1);
    pw(32'h100, 14'h0002, 1'b0);
    pw(32'h300, 14'h0004, 1'b0);
    pw(32'h300, 14'h0020, 1'b1);
    pw(32'h300, 14'h0010, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
